// >>> verilog/satc_top.sv
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module satc_top
  import satc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sample_valid,
  input  wire satc_sample_s      sample,
  output logic                   q,
  output logic                   eval_done
);

  satc_cfg_s                cfg_q;
  logic [DEC_W-1:0]         dec_q;
  logic                     seen_q;
  logic signed [CMP_W-1:0]  value_q;
  logic                     scl_valid;
  logic signed [SCL_W-1:0]  scl0;
  logic signed [SCL_W-1:0]  scl1;
  logic signed [CMP_W-1:0]  cmp_v;
  logic signed [CMP_W-1:0]  on_ext;
  logic signed [CMP_W-1:0]  off_ext;
  logic                     hyst;
  logic                     q_d;
  logic                     aw_have_q;
  logic                     w_have_q;
  logic [ADDR_W-1:0]        awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     aw_hs;
  logic                     w_hs;
  logic                     do_write;
  logic                     b_done;
  logic                     bvalid_d;
  logic                     aw_have_d;
  logic                     w_have_d;
  logic [31:0]              wr_old;
  logic [31:0]              wr_new;
  logic                     wr_hit;
  logic [31:0]              rd_word;
  logic                     rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // register read view

  function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a, output logic hit);
    logic [31:0] w;
    w   = '0;
    hit = 1'b1;
    case (8'(a))
      REG_CTRL:
      begin
        w[CTRL_MODE_BIT] = cfg_q.mode;
        w[CTRL_DEC_LSB +: DEC_W] = dec_q;
      end
      REG_GAIN:   w = 32'(cfg_q.gain);
      REG_OFFSET: w = 32'(cfg_q.offset);
      REG_ON:     w = 32'(cfg_q.on_thr);
      REG_OFFDLT: w = 32'(cfg_q.off_or_delta);
      REG_STATUS:
      begin
        w[STAT_Q_BIT]    = q;
        w[STAT_SEEN_BIT] = seen_q;
      end
      REG_VALUE:  w = 32'(value_q);
      default:    hit = 1'b0;
    endcase
    return w;
  endfunction

  always_comb
  begin
    wr_old = reg_word(awaddr_q, wr_hit);
    rd_word = reg_word(s_axi_araddr, rd_hit);
    wr_new = wr_old;
    for (int b = 0; b < 4; b++)
      if (wstrb_q[b])
        wr_new[8*b +: 8] = wdata_q[8*b +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data in either order, one write at a time

  assign aw_hs     = s_axi_awvalid && s_axi_awready;
  assign w_hs      = s_axi_wvalid && s_axi_wready;
  assign do_write  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign b_done    = s_axi_bvalid && s_axi_bready;
  assign bvalid_d  = do_write || (s_axi_bvalid && !b_done);
  assign aw_have_d = (aw_have_q || aw_hs) && !do_write;
  assign w_have_d  = (w_have_q || w_hs) && !do_write;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end
    else if (ce)
    begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      // ready only drops on the taking edge, so valid is never missed
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready  <= !w_have_d && !bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      if (aw_hs)
        awaddr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_q.mode         <= SATC_DIFF_TRIG;
      cfg_q.gain         <= GAIN_RST;
      cfg_q.offset       <= OFFS_RST;
      cfg_q.on_thr       <= ON_RST;
      cfg_q.off_or_delta <= OFFDLT_RST;
      dec_q              <= DEC_RST;
    end
    else if (ce && do_write)
    begin
      case (8'(awaddr_q))
        REG_CTRL:
        begin
          cfg_q.mode <= satc_mode_e'(wr_new[CTRL_MODE_BIT]);
          dec_q      <= wr_new[CTRL_DEC_LSB +: DEC_W];
        end
        REG_GAIN:   cfg_q.gain   <= GAIN_W'(satc_clamp(wr_new, GAIN_LIM));
        REG_OFFSET: cfg_q.offset <= OFFS_W'(satc_clamp(wr_new, OFFS_LIM));
        REG_ON:     cfg_q.on_thr <= THR_W'(satc_clamp(wr_new, THR_LIM));
        REG_OFFDLT: cfg_q.off_or_delta <= THR_W'(satc_clamp(wr_new, THR_LIM));
        default:    ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scaling and decision

  satc_scale u_scale (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (sample_valid),
    .samp      (sample),
    .gain      (cfg_q.gain),
    .offset    (cfg_q.offset),
    .out_valid (scl_valid),
    .scaled0   (scl0),
    .scaled1   (scl1)
  );

  always_comb
  begin
    on_ext = CMP_W'(cfg_q.on_thr);
    if (cfg_q.mode == SATC_COMPARE)
    begin
      cmp_v   = CMP_W'(scl0) - CMP_W'(scl1);
      off_ext = CMP_W'(cfg_q.off_or_delta);
    end
    else
    begin
      cmp_v   = CMP_W'(scl0);
      off_ext = on_ext + CMP_W'(cfg_q.off_or_delta);
    end
  end

  // decimals never reach the comparison
  satc_decide u_decide (
    .value   (cmp_v),
    .on_thr  (on_ext),
    .off_thr (off_ext),
    .q_prev  (q),
    .hyst    (hyst),
    .q_next  (q_d)
  );

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q         <= 1'b0;
      eval_done <= 1'b0;
      seen_q    <= 1'b0;
      value_q   <= '0;
    end
    else if (ce)
    begin
      eval_done <= scl_valid;
      if (scl_valid)
      begin
        q       <= q_d;
        value_q <= cmp_v;
        seen_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_gain_in_range: assert property (@(posedge clk) disable iff (reset)
    (cfg_q.gain <= 12'sd1000) && (cfg_q.gain >= -12'sd1000) && (cfg_q.offset <= 15'sd10000)
    && (cfg_q.offset >= -15'sd10000)) else $error("gain or offset out of range");

  a_thr_in_range: assert property (@(posedge clk) disable iff (reset)
    (cfg_q.on_thr <= 16'sd20000) && (cfg_q.on_thr >= -16'sd20000)
    && (cfg_q.off_or_delta <= 16'sd20000) && (cfg_q.off_or_delta >= -16'sd20000))
    else $error("threshold out of range");

  a_scale_latency: assert property (@(posedge clk) disable iff (reset)
    (sample_valid && ce) |=> scl_valid)
    else $error("scaled result missing");

  // off = on + delta, so the hysteresis branch must follow the sign of delta
  a_off_derived: assert property (@(posedge clk) disable iff (reset)
    (cfg_q.mode == SATC_DIFF_TRIG) |-> (hyst == (cfg_q.off_or_delta <= 16'sd0)))
    else $error("derived off threshold wrong");

  a_hyst_set: assert property (@(posedge clk) disable iff (reset)
    (scl_valid && ce && hyst && cmp_v > on_ext) |=> q && eval_done)
    else $error("output not set above on");

  a_hyst_clear: assert property (@(posedge clk) disable iff (reset)
    (scl_valid && ce && hyst && cmp_v < off_ext) |=> !q && eval_done)
    else $error("output not cleared below off");

  a_window_level: assert property (@(posedge clk) disable iff (reset)
    (scl_valid && ce && !hyst) |=> q == ($past(cmp_v) >= $past(on_ext)
    && $past(cmp_v) < $past(off_ext))) else $error("window output wrong");

  a_hyst_hold: assert property (@(posedge clk) disable iff (reset)
    (scl_valid && ce && hyst && cmp_v <= on_ext && cmp_v >= off_ext) |=> $stable(q))
    else $error("output not held between thresholds");

  a_diff_value: assert property (@(posedge clk) disable iff (reset)
    (scl_valid && ce && cfg_q.mode == SATC_COMPARE)
    |=> value_q == CMP_W'($past(scl0)) - CMP_W'($past(scl1))) else $error("difference wrong");

  a_write_resp: assert property (@(posedge clk) disable iff (reset)
    (do_write && ce) |=> s_axi_bvalid) else $error("write response missing");

endmodule
`default_nettype wire

// >>> verilog/satc_pkg.sv
package satc_pkg;

  // data widths
  localparam int IN_W   = 16;
  localparam int GAIN_W = 12;
  localparam int OFFS_W = 15;
  localparam int THR_W  = 16;
  localparam int PROD_W = IN_W + GAIN_W;
  localparam int SCL_W  = 24;
  localparam int CMP_W  = 25;
  localparam int DEC_W  = 2;

  // gain carries two decimals: 100 counts per unit
  localparam int GAIN_SCALE = 100;
  localparam int GAIN_LIM   = 1000;
  localparam int OFFS_LIM   = 10000;
  localparam int THR_LIM    = 20000;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_GAIN   = 8'h04;
  localparam logic [7:0] REG_OFFSET = 8'h08;
  localparam logic [7:0] REG_ON     = 8'h0C;
  localparam logic [7:0] REG_OFFDLT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_VALUE  = 8'h18;

  // field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_DEC_LSB  = 1;
  localparam int STAT_Q_BIT    = 0;
  localparam int STAT_SEEN_BIT = 1;

  // reset values
  localparam logic signed [GAIN_W-1:0] GAIN_RST   = 12'h064;
  localparam logic signed [OFFS_W-1:0] OFFS_RST   = 15'h0000;
  localparam logic signed [THR_W-1:0]  ON_RST     = 16'h0000;
  localparam logic signed [THR_W-1:0]  OFFDLT_RST = 16'h0000;
  localparam logic [DEC_W-1:0]         DEC_RST    = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    SATC_DIFF_TRIG = 1'b0,
    SATC_COMPARE   = 1'b1
  } satc_mode_e;

  typedef struct packed {
    satc_mode_e                 mode;
    logic signed [GAIN_W-1:0]   gain;
    logic signed [OFFS_W-1:0]   offset;
    logic signed [THR_W-1:0]    on_thr;
    logic signed [THR_W-1:0]    off_or_delta;
  } satc_cfg_s;

  typedef struct packed {
    logic signed [IN_W-1:0] primary_analog_input;
    logic signed [IN_W-1:0] secondary_analog_input;
  } satc_sample_s;

  // limit a written word to +/-lim
  function automatic logic signed [31:0] satc_clamp(input logic signed [31:0] v,
                                                    input int lim);
    logic signed [31:0] l;
    l = 32'(lim);
    if (v > l)
      return l;
    else if (v < -l)
      return -l;
    return v;
  endfunction

endpackage

// >>> verilog/satc_scale.sv
`timescale 1ns/1ns
`default_nettype none
module satc_scale
  import satc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     in_valid,
  input  wire satc_sample_s             samp,
  input  wire logic signed [GAIN_W-1:0] gain,
  input  wire logic signed [OFFS_W-1:0] offset,
  output logic                          out_valid,
  output logic signed [SCL_W-1:0]       scaled0,
  output logic signed [SCL_W-1:0]       scaled1
);

  logic signed [IN_W-1:0]  raw   [2];
  logic signed [SCL_W-1:0] res_q [2];

  assign raw[0]  = samp.primary_analog_input;
  assign raw[1]  = samp.secondary_analog_input;
  assign scaled0 = res_q[0];
  assign scaled1 = res_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // both channels share one gain and one offset
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] quot;
    assign prod = PROD_W'(raw[c]) * PROD_W'(gain);
    // truncates toward zero; sub-unit remainder is dropped
    assign quot = prod / PROD_W'(GAIN_SCALE);
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        res_q[c] <= '0;
      else if (ce && in_valid)
        res_q[c] <= SCL_W'(quot) + SCL_W'(offset);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      out_valid <= 1'b0;
    else if (ce)
      out_valid <= in_valid;
  end

endmodule
`default_nettype wire

// >>> verilog/satc_decide.sv
`timescale 1ns/1ns
`default_nettype none
module satc_decide
  import satc_pkg::*;
(
  input  wire logic signed [CMP_W-1:0] value,
  input  wire logic signed [CMP_W-1:0] on_thr,
  input  wire logic signed [CMP_W-1:0] off_thr,
  input  wire logic                    q_prev,
  output logic                         hyst,
  output logic                         q_next
);

  always_comb
  begin
    hyst = (on_thr >= off_thr);
    if (hyst)
    begin
      if (value > on_thr)
        q_next = 1'b1;
      else if (value < off_thr)
        q_next = 1'b0;
      else
        q_next = q_prev;
    end
    else
      q_next = (value >= on_thr) && (value < off_thr);
  end

endmodule
`default_nettype wire

// >>> tb/satc_source.sv
`timescale 1ns/1ns
`default_nettype none
module satc_source
  import satc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   fire,
  input  wire logic signed [IN_W-1:0] x_raw,
  input  wire logic signed [IN_W-1:0] y_raw,
  output logic                        sample_valid,
  output satc_sample_s                sample
);
  // bus scrambled outside a scan so stale data never passes for fresh
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sample_valid <= 1'b0;
      sample       <= '0;
    end
    else
    begin
      sample_valid <= fire;
      sample       <= fire ? {x_raw, y_raw} : ~sample;
    end
  end
endmodule
`default_nettype wire

// >>> tb/satc_bench.sv
`timescale 1ns/1ns
`default_nettype none
module satc_bench
  import satc_pkg::*;
;
  logic clk, reset, ce, fire, sv, q, done;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, resp;
  logic signed [IN_W-1:0] x_raw, y_raw;
  satc_sample_s smp;
  int num_errors, cmp_count;
  satc_top dut_u (.clk(clk), .reset(reset), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_valid(sv), .sample(smp), .q(q),
    .eval_done(done));
  satc_source src_u (.clk(clk), .reset(reset), .fire(fire), .x_raw(x_raw),
    .y_raw(y_raw), .sample_valid(sv), .sample(smp));
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 0;
    w = 0;
    // address and data may be taken on different edges
    while (!(aw && w))
    begin
      @(posedge clk);
      if (!aw && awready)
      begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready)
      begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    rd(a, d);
    chk(d, e, m);
  endtask
  task automatic cfg(input int c, input int g, input int o, input int on, input int dl);
    wr(REG_CTRL, 32'(c));
    wr(REG_GAIN, 32'(g));
    wr(REG_OFFSET, 32'(o));
    wr(REG_ON, 32'(on));
    wr(REG_OFFDLT, 32'(dl));
  endtask
  // one scan through the source, then q judged on the done pulse
  task automatic feed(input int x, input int y, input logic e);
    @(posedge clk);
    x_raw <= 16'(x);
    y_raw <= 16'(y);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
    chk({31'h0, q}, {31'h0, e}, "q");
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({31'h0, q}, 32'h0, "q at reset");
    rchk(REG_GAIN, 32'h0000_0064, "gain reset");
    rchk(REG_CTRL, 32'h0000_0000, "ctrl reset");
    rchk(REG_STATUS, 32'h0000_0000, "status reset");
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "read resp");
    rchk(8'h40, 32'h0000_0000, "unmapped data");
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped resp");
    wr(8'h40, 32'h0000_0001);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped wr resp");
  endtask
  task automatic t_limits();
    wr(REG_GAIN, 32'(2000));
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "clamp resp");
    rchk(REG_GAIN, 32'(GAIN_LIM), "gain clamp");
    wr(REG_OFFSET, -32'sd20000);
    rchk(REG_OFFSET, 32'(-OFFS_LIM), "offset clamp");
    wr(REG_ON, 32'(30000));
    rchk(REG_ON, 32'(THR_LIM), "on clamp");
    wr(REG_OFFDLT, -32'sd25000);
    rchk(REG_OFFDLT, 32'(-THR_LIM), "delta clamp");
  endtask
  task automatic t_neg();
    cfg(0, 100, 0, 100, -50);
    feed(100, 0, 1'b0);
    feed(101, 0, 1'b1);
    feed(50, 0, 1'b1);
    feed(49, 0, 1'b0);
    feed(75, 0, 1'b0);
    rchk(REG_STATUS, 32'h0000_0002, "status seen");
  endtask
  task automatic t_scale();
    cfg(0, 250, -5, 100, -50);
    feed(41, 0, 1'b0);
    rchk(REG_VALUE, 32'(97), "scaled up");
    feed(-41, 0, 1'b0);
    rchk(REG_VALUE, 32'(-107), "scaled neg");
  endtask
  task automatic t_pos();
    cfg(0, 100, 0, 100, 50);
    feed(99, 0, 1'b0);
    feed(100, 0, 1'b1);
    feed(149, 0, 1'b1);
    feed(150, 0, 1'b0);
    feed(120, 0, 1'b1);
  endtask
  task automatic t_cmp();
    cfg(7, 10, -30, 20, 5);
    rchk(REG_CTRL, 32'h0000_0007, "decimals kept");
    feed(500, 300, 1'b1);
    rchk(REG_VALUE, 32'(20), "difference");
    feed(610, 400, 1'b1);
    feed(360, 300, 1'b1);
    feed(340, 300, 1'b0);
    cfg(1, 100, 0, 5, 20);
    feed(5, 0, 1'b1);
    feed(20, 0, 1'b0);
    feed(4, 0, 1'b0);
  endtask
  // a scan offered while frozen must leave no trace
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    x_raw <= 16'(10);
    y_raw <= 16'(0);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, done}, 32'h0, "frozen done");
    chk({31'h0, q}, 32'h0, "frozen q");
    ce <= 1'b1;
    @(posedge clk);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    ce = 1'b1;
    fire = 1'b0;
    x_raw = '0;
    y_raw = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_limits();
    t_neg();
    t_scale();
    t_pos();
    t_cmp();
    t_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
